// file: logic/osp_pkg.sv
// Purpose: shared constants for the output-sync I/O pin block
// Assumes: 40 MHz core clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
`default_nettype none
package osp_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_PWM_PER0 = 8'h08;
   localparam logic [7:0] ADDR_PWM_HI0 = 8'h0c;
   localparam logic [7:0] ADDR_PWM_PER1 = 8'h10;
   localparam logic [7:0] ADDR_PWM_HI1 = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // per-pin control field layout, pin n at bit n*8
   localparam int CTRL_PIN_STRIDE = 8;
   localparam int CTRL_MODE_LSB = 0; // 2 bits
   localparam int CTRL_OSRC_LSB = 2; // 2 bits
   localparam int CTRL_INV_BIT = 4;
   // pin functions
   typedef enum logic [1:0] {
      OSP_FN_SYNC = 2'b00,
      OSP_FN_INPUT = 2'b01,
      OSP_FN_OUTPUT = 2'b10
   } osp_fn_e;
   // output sources
   typedef enum logic [1:0] {
      OSP_SRC_ONE = 2'b00,
      OSP_SRC_ZERO = 2'b01,
      OSP_SRC_PWM = 2'b10
   } osp_src_e;
   // reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PWM_PER_RESET = 32'h0000_9c40;
   localparam logic [31:0] PWM_HI_RESET = 32'h0000_4e20;
   // pulse timing
   localparam int CLK_HZ = 40_000_000;
   localparam int PULSE_MIN_US = 30;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_US * (CLK_HZ / 1_000_000));
   localparam int PULSE_OUT_CYC = 2 * PULSE_MIN_CYC;
   localparam int CNT_W = 12;
endpackage
`default_nettype wire

// file: logic/osp_pwm.sv
// Purpose: one pwm generator, period and high time in clock cycles
// Assumes: period >= 1; high >= period gives constant high
// Notes: new settings take effect at once, in the middle of a running period
`default_nettype none
module osp_pwm #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // settings
   input wire logic [W-1:0] period,
   input wire logic [W-1:0] high_time,
   // waveform
   output logic pwm
);
   logic [W-1:0] cnt;

   // period counter wraps at period-1
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (cnt + W'(1) >= period) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + W'(1);
      end
   end

   // high while counter below duty threshold
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pwm <= 1'b0;
      end else begin
         pwm <= (cnt < high_time);
      end
   end
endmodule
`default_nettype wire

// file: logic/osp_top.sv
// Purpose: two sync/io pins steering the output switch, with apb registers
// Assumes: pin inputs synchronous to core_clk; 40 MHz clock
// Notes: pin 0 is turn-on sync, pin 1 is turn-off sync
// Functional notes
// - per-pin invert option flips both received and driven level
// - pin 0 defaults to turn-on synchronisation, bidirectional
// - input mode samples pin level into a readable received level
// - output mode drives constant one, constant zero or pwm
// - pwm frequency and duty set by separate registers
// - local off-to-on switch emits pulse on pin 0
// - pin 0 pulse while on leaves switch unchanged
// - pin 0 pulse while off turns output on
// - pin 1 defaults to turn-off sync, accepts and emits pulses
// - local on-to-off switch emits pulse on pin 1
// - pin 1 pulse while off leaves switch unchanged
// - pin 1 pulse while on turns output off
//
// Chosen here: the APB slave port and the register offsets.
`default_nettype none
module osp_top #(
   parameter int NPINS = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sync pins, oe low while driving
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe_n,
   // output switch state
   output logic output_on
);
   localparam int CW = osp_pkg::CNT_W;
   localparam logic [CW-1:0] MIN_CYC = CW'(osp_pkg::PULSE_MIN_CYC);
   localparam logic [CW-1:0] OUT_CYC = CW'(osp_pkg::PULSE_OUT_CYC);

   // register map, one aligned 32-bit word each
   //   0x00 ctrl, pin n owns the byte at bits n*8:
   //     [1:0] function: 0 sync, 1 input, 2 output, 3 released
   //     [3:2] source: 0 constant one, 1 constant zero, 2 pwm
   //     [4] polarity invert for received and driven level
   //   0x04 cmd, write only: bit0 turn on, bit1 turn off
   //   0x08 pwm period of pin 0, in core clock cycles
   //   0x0c pwm high time of pin 0, in core clock cycles
   //   0x10 pwm period of pin 1
   //   0x14 pwm high time of pin 1
   //   0x18 status, read only:
   //     [0] output switch state
   //     [2:1] received level per pin, after polarity
   //     [4:3] pulse being emitted per pin
   // any other address answers pslverr and leaves all state alone;
   // writes to cmd bits above bit1 and to status are dropped
   // unused ctrl bits are stored and read back as written
   // reset: both pins sync, normal polarity, pwm 40000 and 20000 cycles

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl;
   logic [31:0] pwm_per [NPINS];
   logic [31:0] pwm_hi [NPINS];
   logic cmd_on;
   logic cmd_off;
   logic [NPINS-1:0] rx_level;
   logic [NPINS-1:0] rx_pulse;
   logic [NPINS-1:0] pwm_wave;
   logic [NPINS-1:0] tx_busy;
   logic [NPINS-1:0] pin_sync;
   logic [NPINS-1:0] pin_sel_out;
   logic wr_en;
   logic rd_en;
   logic addr_ok;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // decode is a plain compare chain; only exact word addresses hit,
   // so a byte offset inside a word is refused as well
   // addr_ok only feeds pslverr; each register keeps its own compare
   // map check for the decode; unmapped answers pslverr
   always_comb begin
      if (paddr == osp_pkg::ADDR_CTRL) begin
         addr_ok = 1'b1;
      end else if (paddr == osp_pkg::ADDR_CMD) begin
         addr_ok = 1'b1;
      end else if (paddr == osp_pkg::ADDR_PWM_PER0 || paddr == osp_pkg::ADDR_PWM_HI0) begin
         addr_ok = 1'b1;
      end else if (paddr == osp_pkg::ADDR_PWM_PER1 || paddr == osp_pkg::ADDR_PWM_HI1) begin
         addr_ok = 1'b1;
      end else if (paddr == osp_pkg::ADDR_STATUS) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // ctrl register, reset leaves both pins in sync mode, not inverted
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl <= osp_pkg::CTRL_RESET;
      end else if (wr_en && pready && paddr == osp_pkg::ADDR_CTRL) begin
         ctrl <= pwdata;
      end
   end

   // settings are taken whole; the generator picks them up at once,
   // so a shorter period cuts the running one short
   // period 0 or 1 holds the counter at zero
   // pwm settings, period sets frequency, high time sets duty
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NPINS; i++) begin
            pwm_per[i] <= osp_pkg::PWM_PER_RESET;
            pwm_hi[i] <= osp_pkg::PWM_HI_RESET;
         end
      end else if (wr_en && pready) begin
         if (paddr == osp_pkg::ADDR_PWM_PER0) begin
            pwm_per[0] <= pwdata;
         end else if (paddr == osp_pkg::ADDR_PWM_HI0) begin
            pwm_hi[0] <= pwdata;
         end else if (paddr == osp_pkg::ADDR_PWM_PER1) begin
            pwm_per[1] <= pwdata;
         end else if (paddr == osp_pkg::ADDR_PWM_HI1) begin
            pwm_hi[1] <= pwdata;
         end
      end
   end

   // strobes are registered, so the switch moves one cycle after the
   // write completes; writing both bits turns off if on, else on
   // the strobes last one cycle and never repeat on their own
   // local on/off commands: bit0 turn on, bit1 turn off, one-cycle strobes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_on <= 1'b0;
         cmd_off <= 1'b0;
      end else begin
         cmd_on <= wr_en && pready && paddr == osp_pkg::ADDR_CMD && pwdata[0];
         cmd_off <= wr_en && pready && paddr == osp_pkg::ADDR_CMD && pwdata[1];
      end
   end

   // the first access edge raises pready, the second completes the
   // transfer: writes land and read data is taken there; the wait
   // state costs a cycle but keeps prdata and pslverr registered
   // pslverr rides with pready; a refused read returns zero
   // prdata clears on writes as well
   // apb answer: one wait state so every access takes three cycles, setup included
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !addr_ok;
         if (rd_en && paddr == osp_pkg::ADDR_CTRL) begin
            prdata <= ctrl;
         end else if (rd_en && paddr == osp_pkg::ADDR_PWM_PER0) begin
            prdata <= pwm_per[0];
         end else if (rd_en && paddr == osp_pkg::ADDR_PWM_HI0) begin
            prdata <= pwm_hi[0];
         end else if (rd_en && paddr == osp_pkg::ADDR_PWM_PER1) begin
            prdata <= pwm_per[1];
         end else if (rd_en && paddr == osp_pkg::ADDR_PWM_HI1) begin
            prdata <= pwm_hi[1];
         end else if (rd_en && paddr == osp_pkg::ADDR_STATUS) begin
            prdata <= {27'h0, tx_busy, rx_level, output_on};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-pin logic
   // pin n fields sit at bit n*8 of ctrl
   // each pin carries its own filter, emitter and output stage
   // sync: released when idle, pulses both ways with the far side
   // input: always released, level reported in status only
   // output: always driven with a constant or the pwm level
   // pin 0 in sync turns the output on, pin 1 in sync turns it off
   // invert applies in every function, received and driven alike
   // a pin outside sync neither emits nor accepts pulses
   // the pwm generators always run, so a switch to pwm lands on
   // whatever phase the counter happens to be in
   for (genvar p = 0; p < NPINS; p++) begin : g_pin
      logic [1:0] fn;
      logic [1:0] src;
      logic inv;
      logic active;
      logic [CW-1:0] lo_cnt;
      logic [CW-1:0] tx_cnt;
      logic drv_level;
      logic sync_fire;

      assign fn = ctrl[p*osp_pkg::CTRL_PIN_STRIDE + osp_pkg::CTRL_MODE_LSB +: 2];
      assign src = ctrl[p*osp_pkg::CTRL_PIN_STRIDE + osp_pkg::CTRL_OSRC_LSB +: 2];
      assign inv = ctrl[p*osp_pkg::CTRL_PIN_STRIDE + osp_pkg::CTRL_INV_BIT];

      // every pin owns a generator; it runs even when unused
      // pwm source for this pin
      osp_pwm #(.W(32)) u_pwm (
         .core_clk(core_clk),
         .rst(rst),
         .period(pwm_per[p]),
         .high_time(pwm_hi[p]),
         .pwm(pwm_wave[p])
      );

      // one flop is enough since the pin is taken as synchronous;
      // its reset value matches the pulled-up idle level, no false low
      // register the pin, then undo polarity so active means asserted
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            pin_sync[p] <= 1'b1;
         end else begin
            pin_sync[p] <= pin_in[p];
         end
      end
      assign active = pin_sync[p] ^ inv ? 1'b0 : 1'b1;

      // received level shown in status; pin read even in sync mode
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            rx_level[p] <= 1'b0;
         end else begin
            rx_level[p] <= active;
         end
      end

      // a low shorter than the minimum is ignored; a longer one counts
      // once, at the minimum, and not again until the pin is released
      // the count restarts whenever the pin leaves sync mode
      // low-width filter: a pulse counts once it stays active 30us;
      // own emitted pulse is masked so it does not loop back
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            lo_cnt <= '0;
            rx_pulse[p] <= 1'b0;
         end else begin
            rx_pulse[p] <= 1'b0;
            if (!active || tx_busy[p] || fn != osp_pkg::OSP_FN_SYNC) begin
               lo_cnt <= '0;
            end else if (lo_cnt < MIN_CYC) begin
               lo_cnt <= lo_cnt + CW'(1);
               rx_pulse[p] <= (lo_cnt == MIN_CYC - CW'(1));
            end
         end
      end

      // the emitted pulse is twice the minimum so a far side with a
      // coarse sampler still sees a full width; a command during the
      // pulse cannot restart it, the state has already moved
      // the count and busy flag end together, so busy is never stale
      // no pulse leaves a pin that is not in sync mode
      // emit a pulse on the local transition that matches this pin
      assign sync_fire = (p == 0) ? (cmd_on && !output_on) : (cmd_off && output_on);
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            tx_cnt <= '0;
            tx_busy[p] <= 1'b0;
         end else if (sync_fire && fn == osp_pkg::OSP_FN_SYNC) begin
            tx_cnt <= OUT_CYC;
            tx_busy[p] <= 1'b1;
         end else if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - CW'(1);
            tx_busy[p] <= (tx_cnt != CW'(1));
         end else begin
            tx_busy[p] <= 1'b0;
         end
      end

      // function code 3 is treated as released, nothing drives the pin
      // sync mode drives only while a pulse is being emitted
      // logical output level by function and source
      always_comb begin
         pin_sel_out[p] = 1'b0;
         drv_level = 1'b0;
         if (fn == osp_pkg::OSP_FN_OUTPUT) begin
            pin_sel_out[p] = 1'b1;
            if (src == osp_pkg::OSP_SRC_ONE) begin
               drv_level = 1'b1;
            end else if (src == osp_pkg::OSP_SRC_ZERO) begin
               drv_level = 1'b0;
            end else if (src == osp_pkg::OSP_SRC_PWM) begin
               drv_level = pwm_wave[p];
            end
         end else if (fn == osp_pkg::OSP_FN_SYNC && tx_busy[p]) begin
            pin_sel_out[p] = 1'b1;
            drv_level = 1'b1;
         end
      end

      // registered so pin_out and pin_oe_n switch on the same edge
      // and never glitch while the function changes
      // normal polarity: logic one is a low pin, logic zero a high pin
      // logic one drives low unless inverted; sync idles released
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            pin_out[p] <= 1'b1;
            pin_oe_n[p] <= 1'b1;
         end else begin
            pin_out[p] <= !(drv_level ^ inv);
            pin_oe_n[p] <= !pin_sel_out[p];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // a local command beats a pin pulse in the same cycle since it is
   // what the user asked for; a pulse that matches the present state
   // changes nothing, so two instruments wired together settle
   // rather than bounce back and forth
   // the mode fields are read straight from ctrl for both pins
   // received pulses are one-cycle strobes from the filters
   // output switch: local command first, then pin pulses by state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         output_on <= 1'b0;
      end else if (cmd_off && output_on) begin
         output_on <= 1'b0;
      end else if (cmd_on && !output_on) begin
         output_on <= 1'b1;
      end else if (!output_on && rx_pulse[0] && ctrl[osp_pkg::CTRL_MODE_LSB +: 2] == 2'b00) begin
         output_on <= 1'b1;
      end else if (output_on && rx_pulse[1]
                   && ctrl[osp_pkg::CTRL_PIN_STRIDE + osp_pkg::CTRL_MODE_LSB +: 2] == 2'b00) begin
         output_on <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: bench/osp_checker.sv
// Purpose: port checks for the sync pin block
// Assumes: bound to osp_top; ctrl is shadowed from apb writes
// Notes: pins get three cycles to follow a new ctrl value
`default_nettype none
module osp_checker #(
   parameter int NPINS = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and switch
   input wire logic [NPINS-1:0] pin_in,
   input wire logic [NPINS-1:0] pin_out,
   input wire logic [NPINS-1:0] pin_oe_n,
   input wire logic output_on
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic [31:0] ctrl;
   logic [1:0] age;
   logic [11:0] lo0, lo1;
   logic wr;
   assign wr = psel && penable && pready && pwrite;
   // shadow ctrl; age waits out the registered pin path
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl <= 32'h0;
         age <= 2'h0;
      end else if (wr && paddr == 8'h00) begin
         ctrl <= pwdata;
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   // low run seen from outside; own drive excluded so echoes never count
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lo0 <= 12'h0;
         lo1 <= 12'h0;
      end else begin
         lo0 <= (!pin_in[0] && pin_oe_n[0]) ? lo0 + 12'h1 : 12'h0;
         lo1 <= (!pin_in[1] && pin_oe_n[1]) ? lo1 + 12'h1 : 12'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_bad_addr: assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("unmapped address not refused");
   a_local_on: assert property (
      wr && paddr == 8'h04 && pwdata == 32'h1 && !output_on && ctrl[4:0] == 5'h0
      |-> ##[1:5] (output_on && !pin_oe_n[0] && !pin_out[0]))
      else $error("no low pulse on pin 0 at turn on");
   a_local_off: assert property (
      wr && paddr == 8'h04 && pwdata == 32'h2 && output_on && ctrl[12:8] == 5'h0
      |-> ##[1:5] (!output_on && !pin_oe_n[1] && !pin_out[1]))
      else $error("no low pulse on pin 1 at turn off");
   a_out_level: assert property (
      age == 2'h3 && ctrl[9:8] == 2'h2 && !ctrl[11]
      |-> !pin_oe_n[1] && pin_out[1] == (ctrl[10] ^ ctrl[12]))
      else $error("wrong constant level on pin 1");
   a_in_release: assert property (
      age == 2'h3 && ctrl[9:8] == 2'h1 |-> pin_oe_n[1])
      else $error("input pin driven");
   a_rx_on: assert property (
      lo0 == 12'd1200 && !output_on && ctrl[4:0] == 5'h0 |-> ##[0:3] output_on)
      else $error("received pulse did not turn on");
   a_rx_keep: assert property (
      lo0 == 12'd1200 && output_on && ctrl[4:0] == 5'h0 |-> ##1 output_on [*3])
      else $error("received pulse disturbed on state");
   a_rx_off: assert property (
      lo1 == 12'd1200 && ctrl[12:8] == 5'h0 |-> ##[0:3] !output_on)
      else $error("received pulse did not turn off");
   cover property (lo0 == 12'd1200 && !output_on);
   cover property (lo1 == 12'd1200 && output_on);
   cover property (pready && pslverr);
endmodule
bind osp_top osp_checker #(.NPINS(NPINS)) osp_checker_inst (
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .output_on(output_on));
`default_nettype wire

// file: bench/osp_partner.sv
// Purpose: far-side instrument on the two sync pins
// Assumes: open-collector wiring with a pull-up to the high level
// Notes: the bench decides how long the far side pulls low
`default_nettype none
module osp_partner (
   // device side
   input wire logic [1:0] pin_out,
   input wire logic [1:0] pin_oe_n,
   // far side request
   input wire logic [1:0] pull_low,
   // resolved wire level
   output logic [1:0] pin_in
);
   // pull-up wins when nobody drives; a low from either side wins
   assign pin_in = ~pull_low & (pin_oe_n | pin_out);
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Purpose: self-checking bench for the sync pin block
// Assumes: far side modelled by osp_partner with a pull-up
// Notes: pwm test waits out the 40000 cycle reset period first
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, output_on, err;
   logic [1:0] pin_in, pin_out, pin_oe_n;
   logic [1:0] pull_low = 2'h0;
   int failures = 0;
   int compares = 0;
   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;
   osp_top osp_top_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .output_on(output_on));
   osp_partner osp_partner_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pull_low(pull_low), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; an idle edge follows so calls can chain safely
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic on_is(input logic v);
      chk({31'h0, output_on}, {31'h0, v});
   endtask
   // far side holds low exactly the minimum width, then lets echoes finish
   task automatic rx(input int n);
      pull_low[n] <= 1'b1;
      repeat (osp_pkg::PULSE_MIN_CYC) @(posedge core_clk);
      pull_low[n] <= 1'b0;
      repeat (osp_pkg::PULSE_OUT_CYC + 8) @(posedge core_clk);
   endtask
   // width of the next driven low pulse on pin n
   task automatic pulse(input int n);
      int c;
      c = 0;
      for (int i = 0; i < 20 && pin_oe_n[n] !== 1'b0; i++) @(posedge core_clk);
      while (pin_oe_n[n] === 1'b0 && pin_out[n] === 1'b0 && c < 5000) begin
         c++;
         @(posedge core_clk);
      end
      chk({31'h0, c >= osp_pkg::PULSE_MIN_CYC}, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk({30'h0, pin_oe_n}, 32'h3);
      rdchk(osp_pkg::ADDR_CTRL, osp_pkg::CTRL_RESET);
      rdchk(osp_pkg::ADDR_PWM_PER0, osp_pkg::PWM_PER_RESET);
      rdchk(osp_pkg::ADDR_PWM_HI1, osp_pkg::PWM_HI_RESET);
      apb(1'b0, 8'h1c, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      on_is(1'b0);
   endtask
   task automatic t_local;
      apb(1'b1, osp_pkg::ADDR_CMD, 32'h1);
      pulse(0);
      on_is(1'b1);
      apb(1'b1, osp_pkg::ADDR_CMD, 32'h2);
      pulse(1);
      on_is(1'b0);
   endtask
   task automatic t_rx;
      rx(1);
      on_is(1'b0);
      rx(0);
      on_is(1'b1);
      rx(0);
      on_is(1'b1);
      rx(1);
      on_is(1'b0);
   endtask
   // pin 1 as output: sources one and zero, each with both polarities
   task automatic t_out;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, osp_pkg::ADDR_CTRL, {19'h0, i[1], 1'b0, i[0], 2'h2, 8'h0});
         repeat (3) @(posedge core_clk);
         chk({pin_oe_n[1], pin_out[1]}, {1'b0, i[0] ^ i[1]});
      end
   endtask
   task automatic t_in;
      logic a;
      apb(1'b1, osp_pkg::ADDR_CTRL, 32'h0000_0100);
      pull_low <= 2'h2;
      // pin to status takes two flops; let the new level settle first
      repeat (3) @(posedge core_clk);
      apb(1'b0, osp_pkg::ADDR_STATUS, 32'h0);
      a = rd[2];
      chk({31'h0, a}, 32'h1);
      chk({31'h0, pin_oe_n[1]}, 32'h1);
      pull_low <= 2'h0;
      repeat (3) @(posedge core_clk);
      apb(1'b0, osp_pkg::ADDR_STATUS, 32'h0);
      chk({31'h0, rd[2]}, {31'h0, ~a});
      apb(1'b1, osp_pkg::ADDR_CTRL, 32'h0000_1100);
      pull_low <= 2'h2;
      repeat (3) @(posedge core_clk);
      apb(1'b0, osp_pkg::ADDR_STATUS, 32'h0);
      chk({31'h0, rd[2]}, {31'h0, ~a});
      pull_low <= 2'h0;
   endtask
   // period 4, high 1: one low pin cycle in four under normal polarity
   task automatic t_pwm;
      int lo;
      lo = 0;
      apb(1'b1, osp_pkg::ADDR_PWM_PER1, 32'h4);
      apb(1'b1, osp_pkg::ADDR_PWM_HI1, 32'h1);
      rdchk(osp_pkg::ADDR_PWM_PER1, 32'h4);
      apb(1'b1, osp_pkg::ADDR_CTRL, 32'h0000_0a00);
      repeat (40008) @(posedge core_clk);
      repeat (40) begin
         lo += (pin_out[1] === 1'b0);
         @(posedge core_clk);
      end
      chk(lo, 32'ha);
   endtask
   task automatic print_verdict;
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_reset;
      t_local;
      t_rx;
      t_out;
      t_in;
      t_pwm;
      print_verdict;
   end
   // watchdog sized well above the roughly 60000 cycles of the sequence
   initial begin
      repeat (90000) @(posedge core_clk);
      failures++;
      print_verdict;
   end
endmodule
`default_nettype wire
